//--- verilog/port_ctrl_pkg.sv
/*
 Package for the per-port interrupt mask and loopback control block.
 Holds register indices, byte addresses, field positions, reset values
 and bus encodings. Assumes a 32-bit AHB-Lite register bus.
*/
package port_ctrl_pkg;

	// ----------------------------------------------------------------
	// Register indices (printed offsets, port 1) and byte addresses
	// ----------------------------------------------------------------
	localparam logic [15:0] IRQ_STATUS_IDX = 16'h101B;
	localparam logic [15:0] IRQ_MASK_IDX = 16'h101F;
	localparam logic [15:0] OP_CTRL_IDX = 16'h1020;
	localparam logic [31:0] IRQ_STATUS_ADDR = {14'h0000, IRQ_STATUS_IDX, 2'b00};
	localparam logic [31:0] IRQ_MASK_ADDR = {14'h0000, IRQ_MASK_IDX, 2'b00};
	localparam logic [31:0] OP_CTRL_ADDR = {14'h0000, OP_CTRL_IDX, 2'b00};

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int ACL_BIT = 0;
	localparam int PHY_BIT = 1;
	localparam int TAIL_TAG_BIT = 2;
	localparam int REMOTE_LB_BIT = 6;
	localparam int LOCAL_LB_BIT = 7;

	// ----------------------------------------------------------------
	// Writable masks and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] IRQ_MASK_WMASK = 8'h03;
	localparam logic [7:0] OP_CTRL_WMASK = 8'hC4;
	localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
	localparam logic [7:0] OP_CTRL_RESET = 8'h00;
	localparam logic [7:0] IRQ_STATUS_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Bus encodings and bus-phase state
	// ----------------------------------------------------------------
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;

	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_WRITE = 2'b01,
		PH_READ = 2'b10
	} bus_phase_t;

endpackage

//--- verilog/loopback_ctrl_if.sv
/*
 Interface carrying loopback and host-port controls from the register
 bank to the port datapath. Assumes both ends share one clock.
*/
`timescale 1ns/1ps

interface loopback_ctrl_if;
	logic local_lb;
	logic remote_lb;
	logic tail_tag_en;

	modport regs
	(
		output local_lb,
		output remote_lb,
		output tail_tag_en
	);

	modport path
	(
		input local_lb,
		input remote_lb,
		input tail_tag_en
	);
endinterface // loopback_ctrl_if

//--- verilog/port_loopback_path.sv
/*
 Port datapath that steers byte streams for local and remote loopback.
 Assumes all streams are on hclk and that line data is already retimed
 by the MAC front end.
*/
`timescale 1ns/1ps

module port_loopback_path
	import port_ctrl_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	loopback_ctrl_if.path ctl,
	input wire logic [7:0] fab_eg_data,
	input wire logic fab_eg_valid,
	input wire logic [7:0] line_rx_data,
	input wire logic line_rx_valid,
	output logic [7:0] fab_in_data,
	output logic fab_in_valid,
	output logic [7:0] line_tx_data,
	output logic line_tx_valid,
	output logic host_port
);

	typedef struct packed {
		logic [7:0] fab_in_data;
		logic fab_in_valid;
		logic [7:0] line_tx_data;
		logic line_tx_valid;
		logic host_port;
	} path_state_t;

	path_state_t s_reg;
	path_state_t s_next;

	// ----------------------------------------------------------------
	// Steering
	// ----------------------------------------------------------------
	always_comb
	begin
		s_next = s_reg;
		s_next.host_port = ctl.tail_tag_en;
		// Remote loopback has no elastic buffer: line data returns one cycle later
		if (ctl.remote_lb)
		begin
			s_next.line_tx_data = line_rx_data;
			s_next.line_tx_valid = line_rx_valid;
		end
		else if (ctl.local_lb)
		begin
			s_next.line_tx_data = DATA_RESET;
			s_next.line_tx_valid = 1'b0;
		end
		else
		begin
			s_next.line_tx_data = fab_eg_data;
			s_next.line_tx_valid = fab_eg_valid;
		end
		if (ctl.local_lb)
		begin
			s_next.fab_in_data = fab_eg_data;
			s_next.fab_in_valid = fab_eg_valid;
		end
		else if (ctl.remote_lb)
		begin
			s_next.fab_in_data = DATA_RESET;
			s_next.fab_in_valid = 1'b0;
		end
		else
		begin
			s_next.fab_in_data = line_rx_data;
			s_next.fab_in_valid = line_rx_valid;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign fab_in_data = s_reg.fab_in_data;
	assign fab_in_valid = s_reg.fab_in_valid;
	assign line_tx_data = s_reg.line_tx_data;
	assign line_tx_valid = s_reg.line_tx_valid;
	assign host_port = s_reg.host_port;

endmodule // port_loopback_path

//--- verilog/port_ctrl.sv
/*
 Per-port interrupt mask, interrupt status and operation control bank
 with an AHB-Lite slave, plus the loopback datapath.
 Assumes one 50 MHz hclk, a single AHB-Lite master and same-clock
 event pulses from the PHY and ACL logic.
*/
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps

module port_ctrl
	import port_ctrl_pkg::*;
#(
	parameter bit HAS_PHY = 1'b1
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic phy_irq_event,
	input wire logic acl_irq_event,
	output logic irq,
	input wire logic [7:0] fab_eg_data,
	input wire logic fab_eg_valid,
	input wire logic [7:0] line_rx_data,
	input wire logic line_rx_valid,
	output logic [7:0] fab_in_data,
	output logic fab_in_valid,
	output logic [7:0] line_tx_data,
	output logic line_tx_valid,
	output logic host_port
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		bus_phase_t phase;
		logic [31:0] addr;
		logic [7:0] irq_mask;
		logic [7:0] op_ctrl;
		logic [7:0] irq_status;
		logic [31:0] rdata;
		logic irq;
	} bank_state_t;

	bank_state_t s_reg;
	bank_state_t s_next;

	logic addr_phase;
	logic [7:0] events;
	logic [7:0] wbyte;
	logic [7:0] rd_byte;

	loopback_ctrl_if lb_if ();

	// ----------------------------------------------------------------
	// Event collection
	// ----------------------------------------------------------------
	always_comb
	begin
		events = 8'h00;
		events[ACL_BIT] = acl_irq_event;
		// A port without a PHY never raises the PHY source
		events[PHY_BIT] = phy_irq_event & HAS_PHY;
	end

	assign addr_phase = hsel & hready & htrans[1];
	assign wbyte = hwdata[7:0];

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		s_next = s_reg;
		rd_byte = 8'h00;

		// Data phase of a write lands here
		if (s_reg.phase == PH_WRITE)
		begin
			if (s_reg.addr == IRQ_MASK_ADDR)
			begin
				s_next.irq_mask = wbyte & IRQ_MASK_WMASK;
			end
			else if (s_reg.addr == OP_CTRL_ADDR)
			begin
				s_next.op_ctrl = wbyte & OP_CTRL_WMASK;
			end
			else if (s_reg.addr == IRQ_STATUS_ADDR)
			begin
				s_next.irq_status = s_reg.irq_status & ~wbyte;
			end
		end

		// A new event wins over a clear in the same cycle
		s_next.irq_status = s_next.irq_status | events;

		// Address phase: pick the next data phase
		if (addr_phase)
		begin
			s_next.addr = haddr;
			if (hwrite)
				s_next.phase = PH_WRITE;
			else
				s_next.phase = PH_READ;
		end
		else
		begin
			s_next.phase = PH_IDLE;
		end

		// Read data is taken from the post-write copy so that a read right
		// after a write to the same register returns the new value.
		if (addr_phase && !hwrite)
		begin
			if (haddr == IRQ_MASK_ADDR)
			begin
				rd_byte = s_next.irq_mask;
			end
			else if (haddr == OP_CTRL_ADDR)
			begin
				rd_byte = s_next.op_ctrl;
			end
			else if (haddr == IRQ_STATUS_ADDR)
			begin
				rd_byte = s_next.irq_status;
			end
			else
			begin
				rd_byte = 8'h00;
			end
			s_next.rdata = {24'h000000, rd_byte};
		end

		// Mask 0 enables, mask 1 blocks
		s_next.irq = |(s_next.irq_status & ~s_next.irq_mask);
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s_reg.phase <= PH_IDLE;
			s_reg.addr <= 32'h00000000;
			s_reg.irq_mask <= IRQ_MASK_RESET;
			s_reg.op_ctrl <= OP_CTRL_RESET;
			s_reg.irq_status <= IRQ_STATUS_RESET;
			s_reg.rdata <= 32'h00000000;
			s_reg.irq <= 1'b0;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Zero wait states: every transfer completes in its first data phase
	assign hreadyout = 1'b1;
	assign hresp = HRESP_OKAY;
	assign hrdata = s_reg.rdata;
	assign irq = s_reg.irq;

	assign lb_if.local_lb = s_reg.op_ctrl[LOCAL_LB_BIT];
	assign lb_if.remote_lb = s_reg.op_ctrl[REMOTE_LB_BIT];
	assign lb_if.tail_tag_en = s_reg.op_ctrl[TAIL_TAG_BIT];

	// ----------------------------------------------------------------
	// Datapath
	// ----------------------------------------------------------------
	port_loopback_path u_path
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.ctl(lb_if.path),
		.fab_eg_data(fab_eg_data),
		.fab_eg_valid(fab_eg_valid),
		.line_rx_data(line_rx_data),
		.line_rx_valid(line_rx_valid),
		.fab_in_data(fab_in_data),
		.fab_in_valid(fab_in_valid),
		.line_tx_data(line_tx_data),
		.line_tx_valid(line_tx_valid),
		.host_port(host_port)
	);

endmodule // port_ctrl

//--- testbench/port_ctrl_sva.sv
/*
 Checker for the port control bank, seeing only port_ctrl pins.
 Assumes hready is fed from hreadyout and one hclk domain.
*/
`timescale 1ns/1ps

module port_ctrl_sva
	import port_ctrl_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [31:0] hwdata,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic phy_irq_event,
	input wire logic acl_irq_event,
	input wire logic irq,
	input wire logic [7:0] fab_eg_data,
	input wire logic fab_eg_valid,
	input wire logic [7:0] line_rx_data,
	input wire logic line_rx_valid,
	input wire logic [7:0] fab_in_data,
	input wire logic fab_in_valid,
	input wire logic [7:0] line_tx_data,
	input wire logic line_tx_valid,
	input wire logic host_port
);
	// Write data phase marker; only writes may lower irq or move host_port
	logic wr_reg;
	// Shadow copies of mask and control; a loop mode may drop one stream on purpose
	logic [31:0] waddr_reg;
	logic [7:0] mask_reg;
	logic [7:0] ctl_reg;
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			wr_reg <= 1'b0;
			waddr_reg <= 32'h00000000;
			mask_reg <= IRQ_MASK_RESET;
			ctl_reg <= OP_CTRL_RESET;
		end
		else
		begin
			wr_reg <= hsel && hready && htrans[1] && hwrite;
			if (hsel && hready && htrans[1])
				waddr_reg <= haddr;
			if (wr_reg && waddr_reg == IRQ_MASK_ADDR)
				mask_reg <= hwdata[7:0] & IRQ_MASK_WMASK;
			if (wr_reg && waddr_reg == OP_CTRL_ADDR)
				ctl_reg <= hwdata[7:0] & OP_CTRL_WMASK;
		end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	chk_rdata_upper_zero: assert property (hrdata[31:8] == 24'h0)
		else $error("upper read data not zero");
	chk_fab_in_src: assert property (fab_in_valid |->
		($past(fab_eg_valid) && fab_in_data == $past(fab_eg_data)) ||
		($past(line_rx_valid) && fab_in_data == $past(line_rx_data)))
		else $error("fabric input byte has no source");
	chk_line_tx_src: assert property (line_tx_valid |->
		($past(fab_eg_valid) && line_tx_data == $past(fab_eg_data)) ||
		($past(line_rx_valid) && line_tx_data == $past(line_rx_data)))
		else $error("line output byte has no source");
	chk_fab_byte_kept: assert property (fab_eg_valid &&
		(ctl_reg[LOCAL_LB_BIT] || !ctl_reg[REMOTE_LB_BIT]) |=> fab_in_valid || line_tx_valid)
		else $error("fabric byte dropped");
	chk_rx_byte_kept: assert property (line_rx_valid &&
		(ctl_reg[REMOTE_LB_BIT] || !ctl_reg[LOCAL_LB_BIT]) |=> fab_in_valid || line_tx_valid)
		else $error("line byte dropped");
	chk_mask_blocks_all: assert property (!wr_reg && mask_reg == IRQ_MASK_WMASK |=> !irq)
		else $error("irq raised while fully masked");
	chk_irq_rise_cause: assert property ($rose(irq) |-> $past(acl_irq_event || phy_irq_event || wr_reg))
		else $error("irq rose without cause");
	chk_irq_fall_cause: assert property ($fell(irq) |-> $past(wr_reg))
		else $error("irq fell without write");
	chk_host_port_write: assert property ($changed(host_port) |-> $past(wr_reg) || $past(wr_reg, 2))
		else $error("host port moved without write");
endmodule // port_ctrl_sva

bind port_ctrl port_ctrl_sva port_ctrl_sva_inst (.hclk, .hresetn, .hsel, .haddr, .hwdata, .htrans, .hwrite,
	.hready, .hrdata, .phy_irq_event, .acl_irq_event, .irq, .fab_eg_data, .fab_eg_valid,
	.line_rx_data, .line_rx_valid, .fab_in_data, .fab_in_valid, .line_tx_data,
	.line_tx_valid, .host_port);

//--- testbench/tb.sv
/*
 Self-checking bench for port_ctrl: register table, interrupts, loops.
 Assumes zero-wait AHB-Lite slave and a single-port instance.
*/
`timescale 1ns/1ps

module tb
	import port_ctrl_pkg::*;
;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic phy_irq_event = 1'b0;
	logic acl_irq_event = 1'b0;
	logic fab_eg_valid = 1'b0;
	logic line_rx_valid = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [1:0] m;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic [31:0] q;
	logic [7:0] fab_eg_data = 8'hA0;
	logic [7:0] line_rx_data = 8'h5C;
	logic [7:0] fab_in_data;
	logic [7:0] line_tx_data;
	logic hready, hreadyout, hresp, irq, fab_in_valid, line_tx_valid, host_port;
	int num_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	int i;
	// Rows: address, write data, read-back; first and last rows leave bits set for reset
	logic [95:0] rows [5] = '{{IRQ_MASK_ADDR, 32'hFFFFFFFF, 32'h03},
		{OP_CTRL_ADDR, 32'h3B, 32'h00}, {IRQ_STATUS_ADDR, 32'hFF, 32'h00},
		{32'h00004000, 32'hFF, 32'h00}, {OP_CTRL_ADDR, 32'hFF, 32'hC4}};
	logic [31:0] regs [3] = '{IRQ_STATUS_ADDR, IRQ_MASK_ADDR, OP_CTRL_ADDR};

	port_ctrl port_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
		.phy_irq_event(phy_irq_event), .acl_irq_event(acl_irq_event),
		.fab_eg_data(fab_eg_data), .fab_eg_valid(fab_eg_valid), .line_rx_data(line_rx_data),
		.line_rx_valid(line_rx_valid), .fab_in_data(fab_in_data),
		.fab_in_valid(fab_in_valid), .line_tx_data(line_tx_data),
		.line_tx_valid(line_tx_valid), .host_port(host_port));

	assign hready = hreadyout;
	always #10 hclk = ~hclk;

	task finish_test;
		$display("errors %0d tests %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Hang guard; a normal run is about 112 cycles
	always @(posedge hclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			num_errors++;
			finish_test;
		end
	end

	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			num_errors++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask

	// Single word transfer; read data taken at the data phase end
	task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		hwrite <= w;
		haddr <= a;
		htrans <= HTRANS_NONSEQ;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
		#1;
	endtask

	initial
	begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		for (i = 0; i < 5; i++)
		begin
			xfer(1'b1, rows[i][95:64], rows[i][63:32]);
			xfer(1'b0, rows[i][95:64], 32'h0);
			chk(q, rows[i][31:0]);
			chk({30'h0, hreadyout, hresp}, {30'h0, 1'b1, HRESP_OKAY});
		end
		// Second reset in mid-run, with bits set
		@(posedge hclk);
		hresetn <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		#1;
		chk({29'h0, host_port, irq, fab_in_valid}, 32'h0);
		for (i = 0; i < 3; i++)
		begin
			xfer(1'b0, regs[i], 32'h0);
			chk(q, 32'h0);
		end
		for (i = 0; i < 2; i++)
		begin
			@(posedge hclk);
			{phy_irq_event, acl_irq_event} <= 2'(1 << i);
			@(posedge hclk);
			{phy_irq_event, acl_irq_event} <= 2'h0;
			#1;
			chk({31'h0, irq}, 32'h1);
			xfer(1'b0, IRQ_STATUS_ADDR, 32'h0);
			chk(q, 32'h1 << i);
			xfer(1'b1, IRQ_MASK_ADDR, 32'h1 << i);
			chk({31'h0, irq}, 32'h0);
			xfer(1'b1, IRQ_MASK_ADDR, 32'h0);
			chk({31'h0, irq}, 32'h1);
			xfer(1'b1, IRQ_STATUS_ADDR, 32'h1 << i);
			chk({31'h0, irq}, 32'h0);
		end
		// Event and clear landing on one edge, fully masked: the set must win
		xfer(1'b1, IRQ_MASK_ADDR, 32'h3);
		fork
			xfer(1'b1, IRQ_STATUS_ADDR, 32'h1);
			begin
				repeat (2) @(posedge hclk);
				acl_irq_event <= 1'b1;
				@(posedge hclk);
				acl_irq_event <= 1'b0;
			end
		join
		chk({31'h0, irq}, 32'h0);
		xfer(1'b0, IRQ_STATUS_ADDR, 32'h0);
		chk(q, 32'h1);
		xfer(1'b1, IRQ_MASK_ADDR, 32'h0);
		chk({31'h0, irq}, 32'h1);
		xfer(1'b1, IRQ_STATUS_ADDR, 32'h3);
		chk({31'h0, irq}, 32'h0);
		// One byte per mode keeps the unbuffered loop safe; host port is set in modes 1 and 2 only
		for (i = 0; i < 4; i++)
		begin
			m = 2'(i);
			xfer(1'b1, OP_CTRL_ADDR, {24'h0, m, 3'h0, ^m, 2'h0});
			@(posedge hclk);
			fab_eg_data <= 8'hA0 ^ 8'(i);
			line_rx_data <= 8'h5C ^ 8'(i);
			fab_eg_valid <= 1'b1;
			line_rx_valid <= 1'b1;
			@(posedge hclk);
			fab_eg_valid <= 1'b0;
			line_rx_valid <= 1'b0;
			#1;
			chk({31'h0, host_port}, {31'h0, ^m});
			chk({23'h0, fab_in_valid, fab_in_valid ? fab_in_data : 8'h00},
				m == 2'h1 ? 32'h0 : {23'h0, 1'b1, m[1] ? 8'hA0 ^ 8'(i) : 8'h5C ^ 8'(i)});
			chk({23'h0, line_tx_valid, line_tx_valid ? line_tx_data : 8'h00},
				m == 2'h2 ? 32'h0 : {23'h0, 1'b1, m[0] ? 8'h5C ^ 8'(i) : 8'hA0 ^ 8'(i)});
		end
		finish_test;
	end
endmodule // tb
